// ==== irq_ctrl_pkg.sv ====
// Shared constants and types for the two-level interrupt controller.
package irq_ctrl_pkg;

    // ****************************************************************
    // Register addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'ha8;
    localparam logic [7:0] ADDR_PRIORITY_SELECT  = 8'hb8;
    localparam logic [7:0] ADDR_EXTENDED_ENABLE  = 8'he6;
    localparam logic [7:0] ADDR_EXTENDED_PRIO    = 8'hf6;

    // ****************************************************************
    // Reset values and fixed bits
    // ****************************************************************
    localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;
    localparam logic [7:0] RST_PRIORITY_SELECT  = 8'h80;
    localparam logic [7:0] RST_EXTENDED_ENABLE  = 8'h00;
    localparam logic [7:0] RST_EXTENDED_PRIO    = 8'h00;
    localparam logic [7:0] PRIO_READ_ONE_MASK   = 8'h80;
    localparam logic [7:0] EXT_RESERVED_MASK    = 8'h02;
    localparam logic [7:0] RST_SFR_RDATA        = 8'h00;

    // ****************************************************************
    // Field positions in the primary enable register
    // ****************************************************************
    localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
    localparam int BIT_SPI_IRQ_MASK      = 6;
    localparam int BIT_TIMER2_IRQ_MASK   = 5;
    localparam int BIT_UART_IRQ_MASK     = 4;
    localparam int BIT_TIMER1_IRQ_MASK   = 3;
    localparam int BIT_EXT1_IRQ_MASK     = 2;
    localparam int BIT_TIMER0_IRQ_MASK   = 1;
    localparam int BIT_EXT0_IRQ_MASK     = 0;

    // ****************************************************************
    // Sources and vectors
    // ****************************************************************
    localparam int NUM_SOURCES   = 15;
    localparam int NUM_AUTOCLEAR = 4;
    localparam int SRC_RESERVED  = 8;
    localparam int SRC_IDX_W     = 4;
    localparam logic [15:0] VEC_RESET   = 16'h0000;
    localparam logic [15:0] VEC_BASE    = 16'h0003;
    localparam logic [15:0] VEC_SPACING = 16'h0008;

    // ****************************************************************
    // Latency figures in system clocks
    // ****************************************************************
    localparam int DETECT_CYCLES   = 1;
    localparam int CALL_CYCLES     = 4;
    localparam int RETI_CYCLES     = 5;
    localparam int DIV_CYCLES      = 8;
    localparam int MIN_RESP_CYCLES = DETECT_CYCLES + CALL_CYCLES;
    localparam int MAX_RESP_CYCLES = DETECT_CYCLES + RETI_CYCLES + DIV_CYCLES + CALL_CYCLES;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_RUN  = 2'b01,
        ST_HOLD = 2'b10
    } phase_type;

    typedef logic [NUM_SOURCES-1:0][1:0] src_flags_type;

    typedef struct packed {
        logic [7:0] addr;
        logic       we;
        logic [7:0] wdata;
        logic       bit_we;
        logic [7:0] bit_addr;
        logic       bit_val;
    } sfr_bus_type;

    typedef struct packed {
        logic instr_done;
        logic reti_done;
        logic vector_taken;
    } core_status_type;

    typedef struct packed {
        logic                 req;
        logic                 level;
        logic [SRC_IDX_W-1:0] source;
        logic [15:0]          vector;
    } irq_request_type;

    typedef struct packed {
        logic [7:0]               interrupt_enable;
        logic [7:0]               priority_select;
        logic [7:0]               extended_enable;
        logic [7:0]               extended_prio;
        logic [NUM_AUTOCLEAR-1:0] ext_flags;
        logic                     in_service_hi;
        logic                     in_service_lo;
        phase_type                phase;
        irq_request_type          request;
        logic [7:0]               sfr_rdata;
    } state_type;

endpackage

// ==== irq_fixed_order_pick.sv ====
// Fixed-order picker: lowest set position wins.
`timescale 1ns/100ps

module irq_fixed_order_pick (
    input  wire logic [irq_ctrl_pkg::NUM_SOURCES-1:0] req,
    output logic                                     valid,
    output logic [irq_ctrl_pkg::SRC_IDX_W-1:0]       idx
);
    import irq_ctrl_pkg::*;

    function automatic logic [SRC_IDX_W-1:0] first_set(input logic [NUM_SOURCES-1:0] v);
        logic [SRC_IDX_W-1:0] r;
        r = '0;
        // Scan downward so the lowest position is the last to overwrite
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = SRC_IDX_W'(i);
            end
        end
        return r;
    endfunction

    always_comb begin
        valid = |req;
        idx   = first_set(req);
    end

endmodule

// ==== two_level_interrupt_controller.sv ====
// Two-level interrupt controller with enable/priority registers and vectoring.
`timescale 1ns/100ps

// Contract
// (R1) Per-source priority bit; high request preempts a running low routine.
// (R2) Nothing preempts a high-level routine in service.
// (R3) All priority bits read low after reset; the code resets priority select to 0x80, so bit 7 reads one.
// (R4) Simultaneous requests: high level serviced before low level.
// (R5) Same level: fixed order, position 0 first up to 14.
// (R6) Requests sampled and priority decoded every clock.
// (R7) Minimum response five clocks: one detect plus four call.
// (R8) After return with request pending, one instruction runs before the call.
// (R9) Worst response at most eighteen clocks including return and divide.
// (R10) Equal or lower request waits for return plus one instruction.
// (R11) Vectors 0x0003 step eight to 0x0073; 0x0043 unused; reset vector highest.
// (R12) Only sources 0 to 3 auto-clear their flags on vectoring.
// (R13) Multi-flag sources raise one request when any flag set.
// (R14) Global enable bit 7 overrides all masks.
// (R15) Primary enable layout fixed, resets zero, bit addressable.
// (R16) Extended enable/priority hold sources at bits 0 and 2..7.
// (R17) Flags set regardless of enable; disabled flags ignored.
// (R18) Flag still set after return re-raises request after one instruction.
// (R19) One in-service marker per level, set on vector, cleared on return.
module two_level_interrupt_controller (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire irq_ctrl_pkg::sfr_bus_type     sfr_bus,
    output logic [7:0]                         sfr_rdata,
    input  wire logic [3:0]                    ext_flag_set,
    input  wire logic [3:0]                    ext_flag_clr,
    output logic [3:0]                         ext_flag_pending,
    input  wire irq_ctrl_pkg::src_flags_type   periph_flags,
    input  wire irq_ctrl_pkg::core_status_type core_status,
    output irq_ctrl_pkg::irq_request_type      irq,
    output logic [1:0]                         in_service
);
    import irq_ctrl_pkg::*;

    // ****************************************************************
    // Declarations
    // ****************************************************************
    state_type                st_reg;
    state_type                st_next;
    logic [NUM_SOURCES-1:0]   pending;
    logic [NUM_SOURCES-1:0]   enabled;
    logic [NUM_SOURCES-1:0]   prio_hi;
    logic [NUM_SOURCES-1:0]   eligible;
    logic [NUM_SOURCES-1:0]   cand_hi;
    logic [NUM_SOURCES-1:0]   cand_lo;
    logic                     hi_valid;
    logic                     lo_valid;
    logic [SRC_IDX_W-1:0]     hi_idx;
    logic [SRC_IDX_W-1:0]     lo_idx;
    logic                     grant_valid;
    logic                     grant_level;
    logic [SRC_IDX_W-1:0]     grant_idx;
    logic [NUM_AUTOCLEAR-1:0] auto_clr;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Byte write, plus single-bit write for bit-addressable registers
    function automatic logic [7:0] sfr_update(input logic [7:0]  cur,
                                              input logic [7:0]  base,
                                              input logic        bit_ok,
                                              input sfr_bus_type bus);
        logic [7:0] v;
        v = cur;
        if (bus.we && bus.addr == base) begin
            v = bus.wdata;
        end
        if (bit_ok && bus.bit_we && bus.bit_addr[7:3] == base[7:3]) begin
            v[bus.bit_addr[2:0]] = bus.bit_val;
        end
        return v;
    endfunction

    // (R11) Vector from order number
    function automatic logic [15:0] vector_of(input logic [SRC_IDX_W-1:0] idx);
        return VEC_BASE + VEC_SPACING * {12'h000, idx};
    endfunction

    // ****************************************************************
    // Request collection
    // ****************************************************************
    // (R15) (R16) Map register bits onto order positions
    assign enabled = {st_reg.extended_enable[7:2], 1'b0, st_reg.extended_enable[0],
                      st_reg.interrupt_enable[6:0]};
    assign prio_hi = {st_reg.extended_prio[7:2], 1'b0, st_reg.extended_prio[0],
                      st_reg.priority_select[6:0]};

    generate
        for (genvar i = 0; i < NUM_SOURCES; i++) begin : g_pending
            if (i < NUM_AUTOCLEAR) begin : g_own
                assign pending[i] = st_reg.ext_flags[i];
            end else if (i == SRC_RESERVED) begin : g_resv
                // (R11) Reserved slot never requests
                assign pending[i] = 1'b0;
            end else begin : g_periph
                // (R13) Any flag of the source raises the shared request
                assign pending[i] = |periph_flags[i];
            end
        end
    endgenerate

    // (R14) (R17) Global enable gates masks; flags themselves stay untouched
    assign eligible = pending & enabled
                    & {NUM_SOURCES{st_reg.interrupt_enable[BIT_GLOBAL_IRQ_ENABLE]}};
    // (R1) Split by level
    assign cand_hi  = eligible & prio_hi;
    assign cand_lo  = eligible & ~prio_hi;

    // ****************************************************************
    // Arbitration
    // ****************************************************************
    // (R5) Fixed order within each level
    irq_fixed_order_pick u_pick_hi (
        .req   (cand_hi),
        .valid (hi_valid),
        .idx   (hi_idx)
    );

    irq_fixed_order_pick u_pick_lo (
        .req   (cand_lo),
        .valid (lo_valid),
        .idx   (lo_idx)
    );

    // (R6) Decoded afresh every clock
    always_comb begin
        grant_valid = 1'b0;
        grant_level = 1'b0;
        grant_idx   = '0;
        if (st_reg.phase != ST_RUN || st_reg.in_service_hi) begin
            // (R2) (R10) High routine or post-return window blocks all
            grant_valid = 1'b0;
        end else if (hi_valid) begin
            // (R4) High level first, may preempt a low routine
            grant_valid = 1'b1;
            grant_level = 1'b1;
            grant_idx   = hi_idx;
        end else if (lo_valid && !st_reg.in_service_lo) begin
            // (R10) Low waits while a low routine runs
            grant_valid = 1'b1;
            grant_level = 1'b0;
            grant_idx   = lo_idx;
        end
    end

    // (R12) Auto-clear only the first four flags on vectoring
    always_comb begin
        auto_clr = '0;
        if (core_status.vector_taken && st_reg.request.req
                && st_reg.request.source < SRC_IDX_W'(NUM_AUTOCLEAR)) begin
            auto_clr[st_reg.request.source[1:0]] = 1'b1;
        end
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;

        // (R15) Primary enable, byte and bit writable
        st_next.interrupt_enable = sfr_update(st_reg.interrupt_enable,
                                              ADDR_INTERRUPT_ENABLE, 1'b1, sfr_bus);
        // Top bit has no function and always reads one
        st_next.priority_select  = sfr_update(st_reg.priority_select,
                                              ADDR_PRIORITY_SELECT, 1'b1, sfr_bus)
                                 | PRIO_READ_ONE_MASK;
        // (R16) Reserved bit 1 forced to zero
        st_next.extended_enable  = sfr_update(st_reg.extended_enable,
                                              ADDR_EXTENDED_ENABLE, 1'b0, sfr_bus)
                                 & ~EXT_RESERVED_MASK;
        st_next.extended_prio    = sfr_update(st_reg.extended_prio,
                                              ADDR_EXTENDED_PRIO, 1'b0, sfr_bus)
                                 & ~EXT_RESERVED_MASK;

        // (R17) Set wins over any clear in the same cycle
        st_next.ext_flags = (st_reg.ext_flags & ~ext_flag_clr & ~auto_clr) | ext_flag_set;

        // (R19) Return retires the higher level in service first
        if (core_status.reti_done) begin
            if (st_reg.in_service_hi) begin
                st_next.in_service_hi = 1'b0;
            end else begin
                st_next.in_service_lo = 1'b0;
            end
        end
        // (R19) Taking a vector marks its level
        if (core_status.vector_taken && st_reg.request.req) begin
            if (st_reg.request.level) begin
                st_next.in_service_hi = 1'b1;
            end else begin
                st_next.in_service_lo = 1'b1;
            end
        end

        // (R8) (R18) One instruction must finish after a return
        case (st_reg.phase)
            ST_RUN: begin
                if (core_status.reti_done) begin
                    st_next.phase = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (core_status.instr_done && !core_status.reti_done) begin
                    st_next.phase = ST_RUN;
                end
            end
            default: begin
                st_next.phase = ST_HOLD;
            end
        endcase

        // (R7) Request registered: one detect cycle before the call starts
        if (core_status.vector_taken || core_status.reti_done) begin
            // Drop so the stale candidate is not seen again before markers settle
            st_next.request.req = 1'b0;
        end else begin
            st_next.request.req = grant_valid;
        end
        if (grant_valid) begin
            st_next.request.level  = grant_level;
            st_next.request.source = grant_idx;
            st_next.request.vector = vector_of(grant_idx);
        end

        // Read data registered, unmapped addresses read zero
        case (sfr_bus.addr)
            ADDR_INTERRUPT_ENABLE: st_next.sfr_rdata = st_reg.interrupt_enable;
            ADDR_PRIORITY_SELECT:  st_next.sfr_rdata = st_reg.priority_select;
            ADDR_EXTENDED_ENABLE:  st_next.sfr_rdata = st_reg.extended_enable;
            ADDR_EXTENDED_PRIO:    st_next.sfr_rdata = st_reg.extended_prio;
            default:               st_next.sfr_rdata = RST_SFR_RDATA;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg.interrupt_enable <= RST_INTERRUPT_ENABLE;
            // (R3) Every source starts at low level
            st_reg.priority_select  <= RST_PRIORITY_SELECT;
            st_reg.extended_enable  <= RST_EXTENDED_ENABLE;
            st_reg.extended_prio    <= RST_EXTENDED_PRIO;
            st_reg.ext_flags        <= '0;
            st_reg.in_service_hi    <= 1'b0;
            st_reg.in_service_lo    <= 1'b0;
            st_reg.phase            <= ST_RUN;
            st_reg.request.req      <= 1'b0;
            st_reg.request.level    <= 1'b0;
            st_reg.request.source   <= '0;
            // (R11) Reset vector shown until the first source is selected
            st_reg.request.vector   <= VEC_RESET;
            st_reg.sfr_rdata        <= RST_SFR_RDATA;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // (R9) Controller adds only the detect cycle; return, divide and call are core time
    assign irq              = st_reg.request;
    assign sfr_rdata        = st_reg.sfr_rdata;
    assign ext_flag_pending = st_reg.ext_flags;
    assign in_service       = {st_reg.in_service_hi, st_reg.in_service_lo};

endmodule

// ==== irq_core_model.sv ====
// Behavioural processor core: takes vectors, runs routines, returns.
`timescale 1ns/100ps

module irq_core_model (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire logic                          accept_en,
    input  wire logic [7:0]                    isr_len,
    input  wire irq_ctrl_pkg::irq_request_type irq,
    output irq_ctrl_pkg::core_status_type      core_status,
    output logic [7:0]                         taken_cnt
);
    import irq_ctrl_pkg::*;
    logic [7:0] left;
    logic [1:0] depth;
    logic       tail;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_status <= '0;
            left <= '0;
            depth <= '0;
            tail <= 1'b0;
            taken_cnt <= '0;
        end else begin
            core_status <= '0;
            // Request still shows in the cycle after a take
            if (irq.req && accept_en && !core_status.vector_taken) begin
                core_status.vector_taken <= 1'b1;
                depth <= depth + 2'd1;
                left <= isr_len;
                taken_cnt <= taken_cnt + 8'd1;
            end else if (depth != 2'd0 && left == 8'd0) begin
                core_status.reti_done <= 1'b1;
                depth <= depth - 2'd1;
                left <= isr_len;
                tail <= 1'b1;
            end else begin
                left <= (left != 8'd0) ? left - 8'd1 : left;
                core_status.instr_done <= tail | left[0];
                tail <= 1'b0;
            end
        end
    end
endmodule

// ==== irq_ctrl_asserts.sv ====
// Port-level checks for the two-level interrupt controller.
`timescale 1ns/100ps

module irq_ctrl_asserts (
    input  wire logic                          core_clk,
    input  wire logic                          rst_n,
    input  wire irq_ctrl_pkg::sfr_bus_type     sfr_bus,
    input  wire logic [7:0]                    sfr_rdata,
    input  wire logic [3:0]                    ext_flag_set,
    input  wire logic [3:0]                    ext_flag_pending,
    input  wire irq_ctrl_pkg::core_status_type core_status,
    input  wire irq_ctrl_pkg::irq_request_type irq,
    input  wire logic [1:0]                    in_service
);
    import irq_ctrl_pkg::*;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_vector_map: assert property (irq.req |->
        irq.vector == VEC_BASE + {9'h000, irq.source, 3'b000} && irq.source != 4'd8)
        else $error("vector does not follow source");
    a_high_blocks: assert property (in_service[1] |-> !irq.req)
        else $error("request while high routine runs");
    a_low_only_high: assert property (in_service[0] && irq.req |-> irq.level)
        else $error("low request over low routine");
    a_reti_quiet: assert property (core_status.reti_done |=> !irq.req)
        else $error("request right after return");
    a_wait_instr: assert property (core_status.reti_done ##1 !core_status.instr_done
        |=> !irq.req)
        else $error("request before following instruction");
    a_take_mark: assert property (irq.req && core_status.vector_taken |=>
        !irq.req && in_service[$past(irq.level)])
        else $error("take not marked");
    a_auto_clear: assert property (irq.req && core_status.vector_taken
        && irq.source < 4'd4 && !ext_flag_set[irq.source[1:0]]
        |=> !ext_flag_pending[$past(irq.source[1:0])])
        else $error("flag kept after vectoring");
    a_flag_sets: assert property (|ext_flag_set |=>
        (ext_flag_pending & $past(ext_flag_set)) == $past(ext_flag_set))
        else $error("flag not set");
    a_global_off: assert property (sfr_bus.we && !sfr_bus.bit_we && !sfr_bus.wdata[7]
        && sfr_bus.addr == ADDR_INTERRUPT_ENABLE |-> ##2 !irq.req)
        else $error("request with global enable off");
    a_prio_top: assert property (sfr_bus.addr == ADDR_PRIORITY_SELECT |=> sfr_rdata[7])
        else $error("priority top bit not one");
    a_ext_resv: assert property (sfr_bus.addr == ADDR_EXTENDED_ENABLE
        || sfr_bus.addr == ADDR_EXTENDED_PRIO |=> !sfr_rdata[1])
        else $error("reserved bit not zero");
    c_preempt: cover property (in_service == 2'b11);
    c_reentry: cover property (core_status.reti_done ##[1:8] irq.req);
    c_last_src: cover property (irq.req && irq.source == 4'd14);
endmodule

bind two_level_interrupt_controller irq_ctrl_asserts chk (.core_clk(core_clk), .rst_n(rst_n),
    .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata), .ext_flag_set(ext_flag_set),
    .ext_flag_pending(ext_flag_pending), .core_status(core_status), .irq(irq),
    .in_service(in_service));

// ==== tb_two_level_interrupt_controller.sv ====
// Testbench for the two-level interrupt controller.
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_two_level_interrupt_controller;
    import irq_ctrl_pkg::*;
    logic            core_clk     = 1'b0;
    logic            rst_n        = 1'b0;
    sfr_bus_type     sfr_bus      = '0;
    logic [3:0]      ext_flag_set = '0;
    logic [3:0]      ext_flag_clr = '0;
    src_flags_type   periph_flags = '0;
    logic            accept_en    = 1'b0;
    logic [7:0]      isr_len      = 8'h1e;
    logic [7:0]      sfr_rdata;
    logic [3:0]      ext_flag_pending;
    core_status_type core_status;
    irq_request_type irq;
    logic [1:0]      in_service;
    logic [7:0]      taken_cnt;
    int              num_errors   = 0;
    int              num_checks   = 0;
    logic [7:0]      ra [5]       = '{8'ha8, 8'hb8, 8'he6, 8'hf6, 8'h55};
    logic [7:0]      rv [5]       = '{8'h00, 8'h80, 8'h00, 8'h00, 8'h00};

    always #25 core_clk = ~core_clk;

    two_level_interrupt_controller dut (.core_clk(core_clk), .rst_n(rst_n),
        .sfr_bus(sfr_bus), .sfr_rdata(sfr_rdata), .ext_flag_set(ext_flag_set),
        .ext_flag_clr(ext_flag_clr), .ext_flag_pending(ext_flag_pending),
        .periph_flags(periph_flags), .core_status(core_status), .irq(irq),
        .in_service(in_service));
    irq_core_model core (.core_clk(core_clk), .rst_n(rst_n), .accept_en(accept_en),
        .isr_len(isr_len), .irq(irq), .core_status(core_status), .taken_cnt(taken_cnt));

    // **********
    // Bus, flag, wait and report tasks
    // **********
    task automatic results();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sfr_bus.addr = a;
        sfr_bus.wdata = d;
        sfr_bus.we = 1'b1;
        @(negedge core_clk);
        sfr_bus.we = 1'b0;
    endtask
    task automatic bwr(input logic [7:0] a, input logic v);
        @(negedge core_clk);
        sfr_bus.bit_addr = a;
        sfr_bus.bit_val = v;
        sfr_bus.bit_we = 1'b1;
        @(negedge core_clk);
        sfr_bus.bit_we = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        sfr_bus.addr = a;
        @(negedge core_clk);
        `CHK(sfr_rdata, e)
    endtask
    task automatic ext_pulse(input logic [3:0] s, input logic [3:0] c);
        @(negedge core_clk);
        ext_flag_set = s;
        ext_flag_clr = c;
        @(negedge core_clk);
        ext_flag_set = 4'h0;
        ext_flag_clr = 4'h0;
    endtask
    function automatic logic hit(input int k, input logic [7:0] v);
        case (k)
            0: hit = (irq.req === 1'b1);
            1: hit = (in_service === v[1:0]);
            default: hit = (taken_cnt === v);
        endcase
    endfunction
    // Bounded wait; running out counts as a mismatch
    task automatic wait_for(input int k, input logic [7:0] v, input int lim);
        int n;
        n = 0;
        while (!hit(k, v) && n < lim) begin
            @(negedge core_clk);
            n++;
        end
        if (!hit(k, v)) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, taken_cnt, v);
            results();
        end
    endtask

    // **********
    // Sequence
    // **********
    initial begin
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], rv[i]);
        end
        wr(8'ha8, 8'hff);
        rd(8'ha8, 8'hff);
        wr(8'he6, 8'hff);
        rd(8'he6, 8'hfd);
        bwr(8'hbf, 1'b0);
        rd(8'hb8, 8'h80);
        bwr(8'haf, 1'b0);
        rd(8'ha8, 8'h7f);
        bwr(8'haf, 1'b1);
        $display("test registers done");
        // Core stalled: every request stays visible
        for (int i = 0; i < 15; i++) begin
            if (i == 8) continue;
            if (i < 4) begin
                ext_pulse(4'b0001 << i, 4'h0);
            end else begin
                periph_flags[i] = (i % 2 == 1) ? 2'b10 : 2'b01;
            end
            wait_for(0, 8'h00, 10);
            `CHK(irq.source, i[3:0])
            `CHK(irq.vector, 16'h0003 + 16'(8 * i))
            if (i < 4) begin
                ext_pulse(4'h0, 4'b0001 << i);
            end else begin
                periph_flags[i] = 2'b00;
            end
            repeat (3) @(negedge core_clk);
            `CHK(irq.req, 1'b0)
        end
        $display("test vectors done");
        wr(8'ha8, 8'h7f);
        periph_flags[6] = 2'b11;
        repeat (4) @(negedge core_clk);
        `CHK(irq.req, 1'b0)
        wr(8'ha8, 8'hff);
        wait_for(0, 8'h00, 10);
        `CHK(irq.source, 4'd6)
        bwr(8'hae, 1'b0);
        repeat (3) @(negedge core_clk);
        `CHK(irq.req, 1'b0)
        periph_flags[6] = 2'b00;
        bwr(8'hae, 1'b1);
        bwr(8'ha8, 1'b0);
        ext_pulse(4'h1, 4'h0);
        repeat (2) @(negedge core_clk);
        `CHK({ext_flag_pending[0], irq.req}, 2'b10)
        ext_pulse(4'h0, 4'h1);
        $display("test masks done");
        ext_pulse(4'h4, 4'h0);
        periph_flags[5] = 2'b01;
        periph_flags[12] = 2'b01;
        repeat (3) @(negedge core_clk);
        `CHK(irq.source, 4'd2)
        wr(8'hf6, 8'h20);
        repeat (2) @(negedge core_clk);
        `CHK({irq.level, irq.source}, 5'h1c)
        wr(8'hb8, 8'h20);
        repeat (2) @(negedge core_clk);
        `CHK({irq.level, irq.source}, 5'h15)
        wr(8'hb8, 8'h00);
        ext_pulse(4'h0, 4'h4);
        periph_flags[12] = 2'b00;
        $display("test arbitration done");
        accept_en = 1'b1;
        wait_for(1, 8'h01, 10);
        periph_flags[5] = 2'b00;
        periph_flags[12] = 2'b01;
        wait_for(1, 8'h03, 10);
        `CHK(taken_cnt, 8'h02)
        periph_flags[4] = 2'b01;
        repeat (10) @(negedge core_clk);
        `CHK(irq.req, 1'b0)
        wait_for(2, 8'h03, 80);
        repeat (2) @(negedge core_clk);
        `CHK(in_service, 2'b11)
        periph_flags[12] = 2'b00;
        wait_for(2, 8'h04, 150);
        repeat (2) @(negedge core_clk);
        `CHK(in_service, 2'b01)
        periph_flags[4] = 2'b00;
        wait_for(1, 8'h00, 100);
        $display("test nesting done");
        ext_pulse(4'h2, 4'h0);
        `CHK(irq.req, 1'b0)
        @(negedge core_clk);
        `CHK(irq.req, 1'b1)
        wait_for(2, 8'h05, 10);
        repeat (2) @(negedge core_clk);
        `CHK(ext_flag_pending, 4'h0)
        wait_for(1, 8'h00, 60);
        $display("test auto clear done");
        results();
    end
endmodule
